/* File: adct_cfg.svh */
// constants for the converter timing control block
// assumes one 10 MHz system clock and a plain register port
`ifndef ADCT_CFG_SVH
`define ADCT_CFG_SVH
`define ADCT_ADDR_CTRL   4'h0
`define ADCT_ADDR_STAT   4'h1
`define ADCT_ADDR_RES    4'h2
`define ADCT_ADDR_DIV    4'h3
`define ADCT_CTRL_RST    16'h0000
`define ADCT_BIT_START   0
`define ADCT_BIT_8BIT    1
`define ADCT_BIT_NOPCAL  2
`define ADCT_BIT_IMPR    3
`define ADCT_BIT_ACK     4
`define ADCT_BIT_ST_LO   12
`define ADCT_BIT_TC_LO   14
`define ADCT_LOAD_SYS    8'h06
`define ADCT_SAR10_PC    8'h34
`define ADCT_SAR8_PC     8'h2C
`define ADCT_PCAL_BC     8'h0C
`define ADCT_SAR10_NP    8'h28
`define ADCT_SAR8_NP     8'h20
`define ADCT_CAL_MIN_BC  14'h01E4
`define ADCT_CAL_MAX_BC  14'h2DB0
`endif

/* File: adct_pkg.sv */
// types for the converter timing control block
// assumes adct_cfg.svh supplies the numbers
package adct_pkg;
  typedef enum logic [2:0]
  {
    ADCT_IDLE   = 3'b000,
    ADCT_SAMPLE = 3'b001,
    ADCT_SAR    = 3'b010,
    ADCT_LOAD   = 3'b011
  } adct_state_e;
  typedef struct packed
  {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } adct_bus_s;
endpackage : adct_pkg

/* File: adct_top.sv */
// converter timing control: basic clock, sample, approximate, load
// assumes front end supplies a raw code plus range flags each load
`timescale 1ns/1ns
`include "adct_cfg.svh"
module adct_top #(
  parameter int CAL_NOISE_BC = 2000
) (
  input  wire logic             ref_clk,
  input  wire logic             rstn,
  input  wire adct_pkg::adct_bus_s bus,
  output logic [15:0]           rdata,
  input  wire logic [9:0]       raw_code,
  input  wire logic             below_gnd,
  input  wire logic             above_ref,
  output logic                  sample_en,
  output logic                  conv_done,
  output logic                  cal_busy
);
  logic [15:0] adc_control;
  logic [7:0]  impr_div;
  logic [9:0]  result;
  logic [7:0]  div_cnt;
  logic [7:0]  ph_cnt;
  logic [13:0] cal_cnt;
  logic        start_req;
  adct_pkg::adct_state_e state;
  adct_pkg::adct_state_e next_state;

  // basic clock divide ratio, fixed table or improved register
  function automatic logic [7:0] div_of(input logic [1:0] tc);
    unique case (tc)
      2'b00: div_of = 8'h04;
      2'b01: div_of = 8'h02;
      2'b10: div_of = 8'h10;
      2'b11: div_of = 8'h08;
    endcase
  endfunction : div_of

  wire [1:0] conv_clock_divider_select = adc_control[`ADCT_BIT_TC_LO+:2];
  wire [1:0] sample_period_select      = adc_control[`ADCT_BIT_ST_LO+:2];
  wire       impr = adc_control[`ADCT_BIT_IMPR];
  // improved mode divider: zero treated as one to keep the clock alive
  wire [7:0] impr_n = (impr_div == 8'h00) ? 8'h01 : impr_div;
  wire [7:0] div_n  = impr ? impr_n
                           : div_of(conv_clock_divider_select);
  wire       bc_tick = (div_cnt >= div_n - 8'h01);
  // sample length in basic periods
  wire [7:0] samp_bc = 8'h08 << sample_period_select;
  wire [7:0] sar_bc  = (adc_control[`ADCT_BIT_8BIT] ? `ADCT_SAR8_PC
                        : `ADCT_SAR10_PC)
                       - (adc_control[`ADCT_BIT_NOPCAL] ? `ADCT_PCAL_BC
                          : 8'h00);
  // clamp out-of-range input before loading
  wire [9:0] clamp = below_gnd ? 10'h000 : above_ref ? 10'h3FF
                               : raw_code;
  wire       wr_ctrl = bus.wr && bus.addr == `ADCT_ADDR_CTRL;
  wire       ack = wr_ctrl && bus.wdata[`ADCT_BIT_ACK];
  wire       ph_end_bc = bc_tick && (ph_cnt == 8'h01);
  wire       load_end  = (ph_cnt == 8'h01);
  wire [15:0] rd_mux =
    (bus.addr == `ADCT_ADDR_CTRL) ? adc_control :
    (bus.addr == `ADCT_ADDR_STAT) ? {13'h0000, cal_busy,
                                     (state != adct_pkg::ADCT_IDLE),
                                     conv_done} :
    (bus.addr == `ADCT_ADDR_RES)  ? {6'h00, result} :
    (bus.addr == `ADCT_ADDR_DIV)  ? {8'h00, impr_div} : 16'h0000;

  // register writes; start is a request latched until the sequencer idles
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      adc_control <= `ADCT_CTRL_RST;
      impr_div    <= 8'h04;
      rdata       <= 16'h0000;
    end
    else
    begin
      if (wr_ctrl)
        adc_control <= bus.wdata & 16'hF00E;
      if (bus.wr && bus.addr == `ADCT_ADDR_DIV)
        impr_div <= bus.wdata[7:0];
      rdata <= bus.rd ? rd_mux : 16'h0000;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      start_req <= 1'b0;
    else if (wr_ctrl && bus.wdata[`ADCT_BIT_START])
      start_req <= 1'b1;
    else if (state == adct_pkg::ADCT_IDLE)
      start_req <= 1'b0;
  end

  // basic clock divider, free running
  always_ff @(posedge ref_clk)
  begin
    if (!rstn || bc_tick)
      div_cnt <= 8'h00;
    else
      div_cnt <= div_cnt + 8'h01;
  end

  // sequencer next state
  always_comb
  begin
    next_state = state;
    unique case (state)
      adct_pkg::ADCT_IDLE:   if (start_req) next_state = adct_pkg::ADCT_SAMPLE;
      adct_pkg::ADCT_SAMPLE: if (ph_end_bc) next_state = adct_pkg::ADCT_SAR;
      adct_pkg::ADCT_SAR:    if (ph_end_bc) next_state = adct_pkg::ADCT_LOAD;
      adct_pkg::ADCT_LOAD:   if (load_end)  next_state = adct_pkg::ADCT_IDLE;
      default:               next_state = adct_pkg::ADCT_IDLE;
    endcase
  end

  // phase counters: sample and sar count basic ticks, load counts clocks
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      state     <= adct_pkg::ADCT_IDLE;
      ph_cnt    <= 8'h00;
      sample_en <= 1'b0;
      result    <= 10'h000;
    end
    else
    begin
      state     <= next_state;
      sample_en <= (next_state == adct_pkg::ADCT_SAMPLE);
      if (state == adct_pkg::ADCT_IDLE && start_req)
        ph_cnt <= samp_bc;
      else if (state == adct_pkg::ADCT_SAMPLE && ph_end_bc)
        ph_cnt <= sar_bc;
      else if (state == adct_pkg::ADCT_SAR && ph_end_bc)
        ph_cnt <= `ADCT_LOAD_SYS;
      else if (state == adct_pkg::ADCT_LOAD)
        ph_cnt <= ph_cnt - 8'h01;
      else if (bc_tick && ph_cnt != 8'h00)
        ph_cnt <= ph_cnt - 8'h01;
      if (state == adct_pkg::ADCT_LOAD && load_end)
        result <= clamp;
    end
  end

  // done flag: the load sets it and wins over a same-cycle acknowledge
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      conv_done <= 1'b0;
    else if (state == adct_pkg::ADCT_LOAD && load_end)
      conv_done <= 1'b1;
    else if (ack)
      conv_done <= 1'b0;
  end

  // reset calibration; a busy sequencer pauses it, so conversions extend it
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      cal_cnt  <= 14'h0000;
      cal_busy <= 1'b1;
    end
    else if (cal_busy && bc_tick && state == adct_pkg::ADCT_IDLE)
    begin
      cal_cnt <= cal_cnt + 14'h0001;
      if (cal_cnt + 14'h0001 >= 14'(CAL_NOISE_BC) &&
          cal_cnt + 14'h0001 >= `ADCT_CAL_MIN_BC ||
          cal_cnt + 14'h0001 >= `ADCT_CAL_MAX_BC)
        cal_busy <= 1'b0;
    end
  end

  // checker helpers only; they watch the datapath and drive no output
  logic [7:0] chk_gap;
  logic [7:0] chk_div;
  logic       chk_steady;
  logic [7:0] chk_sar;
  logic [7:0] chk_sar_exp;
  // approximation length due for the mode, kept apart from sar_bc
  wire  [7:0] chk_sar_due =
    adc_control[`ADCT_BIT_8BIT]
      ? (adc_control[`ADCT_BIT_NOPCAL] ? `ADCT_SAR8_NP : `ADCT_SAR8_PC)
      : (adc_control[`ADCT_BIT_NOPCAL] ? `ADCT_SAR10_NP : `ADCT_SAR10_PC);

  // clocks since the last basic tick, and whether the ratio held still
  always_ff @(posedge ref_clk)
  begin
    chk_div <= div_n;
    if (!rstn || bc_tick)
    begin
      chk_gap    <= 8'h01;
      chk_steady <= 1'b1;
    end
    else
    begin
      chk_gap <= chk_gap + 8'h01;
      if (div_n != chk_div)
        chk_steady <= 1'b0;
    end
  end

  // basic ticks spent approximating in the current conversion
  always_ff @(posedge ref_clk)
  begin
    if (!rstn || state != adct_pkg::ADCT_SAR)
      chk_sar <= 8'h00;
    else if (bc_tick)
      chk_sar <= chk_sar + 8'h01;
  end

  // latch the due length as sampling ends; later writes cannot move it
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      chk_sar_exp <= 8'h00;
    else if (state == adct_pkg::ADCT_SAMPLE && ph_end_bc)
      chk_sar_exp <= chk_sar_due;
  end

  property p_done_load;
    @(posedge ref_clk) disable iff (!rstn)
    (state == adct_pkg::ADCT_LOAD && load_end) |=> conv_done;
  endproperty
  a_done_load: assert property (p_done_load)
    else $error("done not set");
  property p_done_hold;
    @(posedge ref_clk) disable iff (!rstn)
    (conv_done && !ack) |=> conv_done;
  endproperty
  a_done_hold: assert property (p_done_hold)
    else $error("done dropped");
  property p_done_ack;
    @(posedge ref_clk) disable iff (!rstn)
    (ack && !(state == adct_pkg::ADCT_LOAD && load_end)) |=> !conv_done;
  endproperty
  a_done_ack: assert property (p_done_ack)
    else $error("done not cleared");
  property p_load_len;
    @(posedge ref_clk) disable iff (!rstn)
    $rose(state == adct_pkg::ADCT_LOAD) |->
      (state == adct_pkg::ADCT_LOAD)[*6] ##1 state == adct_pkg::ADCT_IDLE;
  endproperty
  a_load_len: assert property (p_load_len)
    else $error("load not 6 clocks");
  property p_clamp_lo;
    @(posedge ref_clk) disable iff (!rstn)
    (state == adct_pkg::ADCT_LOAD && load_end && below_gnd)
      |=> result == 10'h000;
  endproperty
  a_clamp_lo: assert property (p_clamp_lo)
    else $error("low clamp");
  property p_clamp_hi;
    @(posedge ref_clk) disable iff (!rstn)
    (state == adct_pkg::ADCT_LOAD && load_end && !below_gnd && above_ref)
      |=> result == 10'h3FF;
  endproperty
  a_clamp_hi: assert property (p_clamp_hi)
    else $error("high clamp");
  property p_div_fix;
    @(posedge ref_clk) disable iff (!rstn)
    !impr && conv_clock_divider_select == 2'b10 |-> div_n == 8'h10;
  endproperty
  a_div_fix: assert property (p_div_fix)
    else $error("div 16 wrong");
  property p_div_period;
    @(posedge ref_clk) disable iff (!rstn)
    (bc_tick && chk_steady && div_n == chk_div) |-> chk_gap == div_n;
  endproperty
  a_div_period: assert property (p_div_period)
    else $error("basic tick spacing");
  property p_samp;
    @(posedge ref_clk) disable iff (!rstn)
    (state == adct_pkg::ADCT_IDLE && start_req) |=>
      ph_cnt == (8'h08 << $past(sample_period_select));
  endproperty
  a_samp: assert property (p_samp)
    else $error("sample length");
  property p_seq;
    @(posedge ref_clk) disable iff (!rstn)
    (state == adct_pkg::ADCT_IDLE && start_req) |=>
      (state == adct_pkg::ADCT_SAMPLE && sample_en);
  endproperty
  a_seq: assert property (p_seq)
    else $error("sample phase not entered");
  property p_sar;
    @(posedge ref_clk) disable iff (!rstn)
    (state == adct_pkg::ADCT_SAMPLE && ph_end_bc) |=>
      ph_cnt + ($past(adc_control[`ADCT_BIT_NOPCAL]) ? 8'h0C : 8'h00)
      == ($past(adc_control[`ADCT_BIT_8BIT]) ? 8'h2C : 8'h34);
  endproperty
  a_sar: assert property (p_sar)
    else $error("sar length");
  property p_sar_ticks;
    @(posedge ref_clk) disable iff (!rstn)
    (state == adct_pkg::ADCT_SAR && ph_end_bc) |->
      chk_sar + 8'h01 == chk_sar_exp;
  endproperty
  a_sar_ticks: assert property (p_sar_ticks)
    else $error("approximation length");
  property p_cal_min;
    @(posedge ref_clk) disable iff (!rstn)
    $fell(cal_busy) |-> cal_cnt >= `ADCT_CAL_MIN_BC;
  endproperty
  a_cal_min: assert property (p_cal_min)
    else $error("cal too short");
  property p_cal_max;
    @(posedge ref_clk) disable iff (!rstn)
    cal_busy |-> cal_cnt < `ADCT_CAL_MAX_BC;
  endproperty
  a_cal_max: assert property (p_cal_max)
    else $error("cal too long");
  property p_cal_hold;
    @(posedge ref_clk) disable iff (!rstn)
    (cal_busy && state != adct_pkg::ADCT_IDLE) |=> $stable(cal_cnt);
  endproperty
  a_cal_hold: assert property (p_cal_hold)
    else $error("cal ran");
  c_conv: cover property (@(posedge ref_clk) $rose(conv_done));
  c_cal:  cover property (@(posedge ref_clk) $fell(cal_busy));
  c_impr: cover property (@(posedge ref_clk) impr && bc_tick);
  c_nopcal: cover property (@(posedge ref_clk) ph_end_bc &&
    state == adct_pkg::ADCT_SAR && adc_control[`ADCT_BIT_NOPCAL]);
endmodule : adct_top

/* File: adct_front.sv */
// front end model: analog input held as a code plus range flags
// assumes the bench picks the input case before each conversion
`timescale 1ns/1ns
module adct_front (
  input  wire logic       ref_clk,
  input  wire logic       sample_en,
  input  wire logic [9:0] set_code,
  input  wire logic [1:0] set_range,
  output logic [9:0]      raw_code = 10'h000,
  output logic            below_gnd = 1'b0,
  output logic            above_ref = 1'b0
);
  // lines move only while sampling, so the load sees a held value
  always @(posedge ref_clk)
  begin
    if (sample_en)
    begin
      raw_code  <= set_code;
      below_gnd <= set_range == 2'h1;
      above_ref <= set_range == 2'h2;
    end
  end
endmodule : adct_front

/* File: testbench.sv */
// self-checking bench for the converter timing control block
// assumes adct_top and the front end model are compiled first
`timescale 1ns/1ns
`include "adct_cfg.svh"
module testbench;
  logic                ref_clk = 1'b0;
  logic                rstn = 1'b0;
  adct_pkg::adct_bus_s bus = '0;
  logic [15:0]         rdata, w, ev;
  logic [9:0]          raw_code, set_code = 10'h000;
  logic [1:0]          set_range = 2'h0, tc, st;
  logic                below_gnd, above_ref, sample_en, conv_done;
  logic                cal_busy, b8, np, im;
  int                  fails = 0, total_checks = 0, n, dv, sar, e, sp;
  int                  cyc = 0, sn = 0;
  always #50 ref_clk = ~ref_clk;
  // cycles since reset release, for the calibration length
  always @(posedge ref_clk) cyc <= rstn ? cyc + 1 : 0;
  // clocks with sample_en high since the last register write
  always @(posedge ref_clk) sn <= bus.wr ? 0 : sample_en ? sn + 1 : sn;
  adct_top #(.CAL_NOISE_BC(484)) u_adct_top (
    .ref_clk(ref_clk), .rstn(rstn), .bus(bus), .rdata(rdata),
    .raw_code(raw_code), .below_gnd(below_gnd), .above_ref(above_ref),
    .sample_en(sample_en), .conv_done(conv_done), .cal_busy(cal_busy));
  adct_front u_adct_front (
    .ref_clk(ref_clk), .sample_en(sample_en), .set_code(set_code),
    .set_range(set_range), .raw_code(raw_code), .below_gnd(below_gnd),
    .above_ref(above_ref));
  task automatic complete_run;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : complete_run
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // one-cycle strobes, always released before the next access
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge ref_clk);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus <= '0;
  endtask : wr
  task automatic rdchk(input logic [3:0] a, input logic [15:0] x);
    @(posedge ref_clk);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    bus <= '0;
    #1 check(rdata, x);
  endtask : rdchk
  // bounded wait for done high or calibration idle
  task automatic wait_for(input bit cal, input int lim);
    n = 0;
    do
    begin
      @(posedge ref_clk);
      #1 n++;
    end while ((cal ? cal_busy !== 1'b0 : conv_done !== 1'b1) && n < lim);
    if (n >= lim)
    begin
      fails++;
      complete_run();
    end
  endtask : wait_for
  initial
  begin
    repeat (4) @(posedge ref_clk);
    rstn <= 1'b1;
    rdchk(`ADCT_ADDR_CTRL, `ADCT_CTRL_RST);
    rdchk(`ADCT_ADDR_DIV, 16'h0004);
    rdchk(`ADCT_ADDR_STAT, 16'h0004);
    // conversion inside calibration: runs, calibration pauses
    wr(`ADCT_ADDR_CTRL, 16'h0001);
    wait_for(0, 400);
    check(cal_busy, 1'b1);
    wr(`ADCT_ADDR_CTRL, 16'h0010);
    wait_for(1, 3000);
    check(cyc >= 2176 && cyc <= 2260, 1'b1);
    // table of selects, widths and post-calibration on and off
    for (int i = 0; i < 9; i++)
    begin
      tc = i[1:0];
      st = 2'(i + 1);
      b8 = i[1];
      np = i[2];
      im = i == 8;
      if (im)
        wr(`ADCT_ADDR_DIV, 16'h0005);
      // every fixed ratio keeps 10 MHz within 0.5..20 MHz
      dv = im ? 5 : tc == 0 ? 4 : tc == 1 ? 2 : tc == 2 ? 16 : 8;
      sar = (b8 ? 44 : 52) - (np ? 12 : 0);
      sp = (8 << st) * dv;
      e = sp + sar * dv + 6;
      set_range = 2'(i % 3);
      set_code = 10'h155 + 10'(i);
      w = {tc, st, 8'h00, im, np, b8, 1'b1};
      wr(`ADCT_ADDR_CTRL, w);
      wait_for(0, 3000);
      check(n >= e - dv && n <= e + 4, 1'b1);
      check(sn > sp - dv && sn <= sp, 1'b1);
      check(sample_en, 1'b0);
      ev = set_range == 1 ? 16'h0000 : set_range == 2 ? 16'h03FF
           : {6'h00, set_code};
      rdchk(`ADCT_ADDR_RES, ev);
      rdchk(`ADCT_ADDR_CTRL, w & 16'hF00E);
      rdchk(`ADCT_ADDR_STAT, 16'h0001);
      check(conv_done, 1'b1);
      wr(`ADCT_ADDR_CTRL, (w & 16'hF00E) | 16'h0010);
      #1 check(conv_done, 1'b0);
    end
    wr(`ADCT_ADDR_RES, 16'hFFFF);
    rdchk(`ADCT_ADDR_RES, ev);
    rdchk(4'hF, 16'h0000);
    complete_run();
  end
endmodule : testbench
